// file: verilog/adt_params.svh
// constants for the area-2 dram timing and configuration block
`ifndef ADT_PARAMS_SVH
`define ADT_PARAMS_SVH
`define ADT_ADDR_W          4
`define ADT_OFF_CONTROL     4'h0
`define ADT_OFF_STATUS      4'h1
`define ADT_CTRL_RESET      16'h0000
`define ADT_CTRL_WMASK      16'hF35E
`define ADT_TPC_HI          15
`define ADT_TPC_LO          14
`define ADT_RCD_HI          13
`define ADT_RCD_LO          12
`define ADT_TRAS_HI         9
`define ADT_TRAS_LO         8
`define ADT_BURST_BIT       6
`define ADT_AMX_HI          4
`define ADT_AMX_LO          3
`define ADT_REFRESH_ON_BIT        2
`define ADT_REFRESH_TYPE_SELECT_BIT       1
`define ADT_CNT_W           4
`define ADT_TPC_BASE        4'h1
`define ADT_TPC_SELF_BASE   4'h2
`define ADT_TPC_SELF_STEP   4'h3
`define ADT_RCD_BASE        4'h1
`define ADT_TRAS_BASE       4'h2
`define ADT_COL_BASE        4'h8
`define ADT_AREA2_WIDTH     2'h1
`define ADT_WIDTH_16        2'h1
`endif

// file: verilog/adt_pkg.sv
// types shared by the area-2 dram timing block
package adt_pkg;
    typedef struct packed {
        logic [1:0] ras_precharge_time;
        logic [1:0] ras_to_cas_delay;
        logic [1:0] cbr_ras_assert_time;
        logic       page_burst_on;
        logic [1:0] column_width_sel;
        logic       refresh_on;
        logic       refresh_type_select;
    } adt_cfg_t;

    typedef struct packed {
        logic [3:0] precharge_cycles;
        logic [3:0] ras_cas_cycles;
        logic [3:0] cbr_ras_cycles;
        logic [3:0] column_bits;
    } adt_timing_t;

    typedef enum logic [2:0] {
        ADT_IDLE,
        ADT_CBR_WAIT_BUS,
        ADT_CBR_RAS,
        ADT_SELF_WAIT_BUS,
        ADT_SELF,
        ADT_PRECHARGE
    } adt_state_t;
endpackage

// file: verilog/adt_timing_decode.sv
// decodes the control fields into cycle counts
`include "adt_params.svh"
module adt_timing_decode
    import adt_pkg::*;
(
    input  wire adt_cfg_t    cfg_i,
    input  wire logic        after_self_i,
    output adt_timing_t      timing_o
);
    always_comb begin
        // precharge lengthens after leaving self-refresh: 2,5,8,11 vs 1..4
        if (after_self_i) begin
            timing_o.precharge_cycles = `ADT_TPC_SELF_BASE + `ADT_TPC_SELF_STEP * {2'h0, cfg_i.ras_precharge_time};
        end else begin
            timing_o.precharge_cycles = `ADT_TPC_BASE + {2'h0, cfg_i.ras_precharge_time};
        end
        timing_o.ras_cas_cycles = `ADT_RCD_BASE + {2'h0, cfg_i.ras_to_cas_delay};
        timing_o.cbr_ras_cycles = `ADT_TRAS_BASE + {2'h0, cfg_i.cbr_ras_assert_time};
        timing_o.column_bits    = `ADT_COL_BASE + {2'h0, cfg_i.column_width_sel};
    end
endmodule

// file: verilog/adt_core.sv
// area-2 dram control register, refresh sequencing and timing outputs
// What this block does
// - sixteen-bit control register cleared only by power-on reset, kept otherwise
// - area 2 with dram always uses a sixteen-bit data bus
// - bits 15:14 pick precharge 1-4 cycles, or 2,5,8,11 after self-refresh
// - bits 13:12 pick ras-to-cas delay of 1 to 4 cycles
// - bits 9:8 pick cbr ras assert time of 2 to 5 cycles
// - bit 6 enables fast page mode bursts
// - bits 4:3 pick column address width of 8 to 11 bits
// - bit 2 enables refresh
// - bit 1 selects cbr or self-refresh, only while refresh enabled
// - cbr refresh on timer request, after ending any running bus cycle
// - self-refresh entered after bus cycle ends; requests ignored while in it
`include "adt_params.svh"
module adt_core
    import adt_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic [`ADT_ADDR_W-1:0] addr_i,
    input  wire logic [15:0]            wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    input  wire logic                   refresh_req_i,
    input  wire logic                   bus_busy_i,
    output logic      [15:0]            rdata_o,
    output logic                        bus_hold_o,
    output logic                        ras_refresh_o,
    output logic                        self_refresh_o,
    output logic                        page_burst_o,
    output logic      [1:0]             area2_width_o,
    output logic      [3:0]             ras_cas_cycles_o,
    output logic      [3:0]             precharge_cycles_o,
    output logic      [3:0]             column_bits_o
);
    logic [15:0]           ctrl_r,  ctrl_nxt;
    logic [15:0]           rdata_r, rdata_nxt;
    adt_state_t            state_r, state_nxt;
    logic [`ADT_CNT_W-1:0] cnt_r,   cnt_nxt;
    logic                  after_self_r, after_self_nxt;
    logic                  pend_r,  pend_nxt;
    logic                  hold_r, ras_r, self_r, burst_r;
    logic [1:0]            width_r;
    logic [3:0]            rcd_r, tpc_r, col_r;
    logic                  hold_nxt, ras_nxt, self_nxt, burst_nxt;
    logic [1:0]            width_nxt;
    logic [3:0]            rcd_nxt, tpc_nxt, col_nxt;
    adt_cfg_t              cfg;
    adt_timing_t           timing;

    assign cfg.ras_precharge_time  = ctrl_r[`ADT_TPC_HI:`ADT_TPC_LO];
    assign cfg.ras_to_cas_delay    = ctrl_r[`ADT_RCD_HI:`ADT_RCD_LO];
    assign cfg.cbr_ras_assert_time = ctrl_r[`ADT_TRAS_HI:`ADT_TRAS_LO];
    assign cfg.page_burst_on       = ctrl_r[`ADT_BURST_BIT];
    assign cfg.column_width_sel    = ctrl_r[`ADT_AMX_HI:`ADT_AMX_LO];
    assign cfg.refresh_on          = ctrl_r[`ADT_REFRESH_ON_BIT];
    assign cfg.refresh_type_select = ctrl_r[`ADT_REFRESH_TYPE_SELECT_BIT];

    // the after-self flag lengthens precharge until that first precharge is done
    adt_timing_decode u_decode (
        .cfg_i        (cfg),
        .after_self_i (after_self_r),
        .timing_o     (timing)
    );

    // register file; rst_i is the power-on reset, no other reset reaches it
    // every access takes one cycle, so the bus is never made to wait
    always_comb begin
        ctrl_nxt  = ctrl_r;
        rdata_nxt = 16'h0000;
        if (wr_i && addr_i == `ADT_OFF_CONTROL) begin
            ctrl_nxt = wdata_i & `ADT_CTRL_WMASK;
        end
        if (rd_i) begin
            case (addr_i)
                `ADT_OFF_CONTROL: rdata_nxt = ctrl_r;
                // status is read only; a write to it is dropped
                `ADT_OFF_STATUS:  rdata_nxt = {12'h000, pend_r, after_self_r, self_r, ras_r};
                default:          rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            // only power-on reset clears the control word
            ctrl_r  <= `ADT_CTRL_RESET;
            rdata_r <= 16'h0000;
        end else begin
            ctrl_r  <= ctrl_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // refresh sequencer
    always_comb begin
        state_nxt      = state_r;
        cnt_nxt        = cnt_r;
        after_self_nxt = after_self_r;
        pend_nxt       = pend_r;
        // a request that arrives while one is being served is kept, not lost
        if (refresh_req_i && state_r != ADT_SELF && cfg.refresh_on && !cfg.refresh_type_select) begin
            pend_nxt = 1'b1;
        end
        case (state_r)
            ADT_IDLE: begin
                // self-refresh takes priority over a pending cbr request
                if (cfg.refresh_on && cfg.refresh_type_select) begin
                    state_nxt = ADT_SELF_WAIT_BUS;
                end else if (cfg.refresh_on && pend_r) begin
                    state_nxt = ADT_CBR_WAIT_BUS;
                end
            end
            ADT_CBR_WAIT_BUS: begin
                // running cycle is ended first, then the refresh runs
                if (!bus_busy_i) begin
                    state_nxt = ADT_CBR_RAS;
                    pend_nxt  = refresh_req_i;
                    // counts down to zero, so load the length less one
                    cnt_nxt   = timing.cbr_ras_cycles - 4'h1;
                end
            end
            ADT_CBR_RAS: begin
                if (cnt_r == 4'h0) begin
                    state_nxt = ADT_PRECHARGE;
                    cnt_nxt   = timing.precharge_cycles - 4'h1;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            ADT_SELF_WAIT_BUS: begin
                if (!bus_busy_i) begin
                    state_nxt = ADT_SELF;
                end
            end
            ADT_SELF: begin
                // a request held from before the entry is dropped as well
                pend_nxt = 1'b0;
                if (!(cfg.refresh_on && cfg.refresh_type_select)) begin
                    after_self_nxt = 1'b1;
                    state_nxt      = ADT_PRECHARGE;
                    // after_self_r is only set at this edge, so the long precharge is worked out here
                    cnt_nxt        = `ADT_TPC_SELF_BASE + `ADT_TPC_SELF_STEP * {2'h0, cfg.ras_precharge_time} - 4'h1;
                end
            end
            ADT_PRECHARGE: begin
                if (cnt_r == 4'h0) begin
                    state_nxt      = ADT_IDLE;
                    // the long precharge applies once only
                    after_self_nxt = 1'b0;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            default: state_nxt = ADT_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r      <= ADT_IDLE;
            cnt_r        <= 4'h0;
            after_self_r <= 1'b0;
            pend_r       <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            cnt_r        <= cnt_nxt;
            after_self_r <= after_self_nxt;
            pend_r       <= pend_nxt;
        end
    end

    // hold, ras and self outputs use the next state so they switch together with the state register
    always_comb begin
        hold_nxt  = state_nxt != ADT_IDLE && state_nxt != ADT_CBR_WAIT_BUS && state_nxt != ADT_SELF_WAIT_BUS;
        ras_nxt   = state_nxt == ADT_CBR_RAS;
        self_nxt  = state_nxt == ADT_SELF;
        burst_nxt = cfg.page_burst_on;
        width_nxt = `ADT_WIDTH_16;
        rcd_nxt   = timing.ras_cas_cycles;
        tpc_nxt   = timing.precharge_cycles;
        col_nxt   = timing.column_bits;
    end

    // registered outputs toward the bus cycle engine and dram pins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_r  <= 1'b0;
            ras_r   <= 1'b0;
            self_r  <= 1'b0;
            burst_r <= 1'b0;
            width_r <= `ADT_AREA2_WIDTH;
            rcd_r   <= `ADT_RCD_BASE;
            tpc_r   <= `ADT_TPC_BASE;
            col_r   <= `ADT_COL_BASE;
        end else begin
            hold_r  <= hold_nxt;
            ras_r   <= ras_nxt;
            self_r  <= self_nxt;
            burst_r <= burst_nxt;
            width_r <= width_nxt;
            rcd_r   <= rcd_nxt;
            tpc_r   <= tpc_nxt;
            col_r   <= col_nxt;
        end
    end

    // every output is a plain copy of a flip-flop
    assign rdata_o            = rdata_r;
    assign bus_hold_o         = hold_r;
    assign ras_refresh_o      = ras_r;
    assign self_refresh_o     = self_r;
    assign page_burst_o       = burst_r;
    assign area2_width_o      = width_r;
    assign ras_cas_cycles_o   = rcd_r;
    assign precharge_cycles_o = tpc_r;
    assign column_bits_o      = col_r;
endmodule

// file: verif/adt_core_properties.sv
// concurrent checks on the area-2 dram timing block
module adt_core_properties (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [3:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic        bus_busy_i,
    input wire logic [15:0] rdata_o,
    input wire logic        bus_hold_o,
    input wire logic        ras_refresh_o,
    input wire logic        self_refresh_o,
    input wire logic        page_burst_o,
    input wire logic [1:0]  area2_width_o,
    input wire logic [3:0]  ras_cas_cycles_o,
    input wire logic [3:0]  precharge_cycles_o,
    input wire logic [3:0]  column_bits_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] sh_r;
    logic [3:0]  cnt_r;
    // shadow of the control word, so no internal probes are needed
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sh_r  <= 16'h0000;
            cnt_r <= 4'h0;
        end else begin
            if (wr_i && addr_i == 4'h0) sh_r <= wdata_i & 16'hF35E;
            cnt_r <= ras_refresh_o ? cnt_r + 4'h1 : 4'h0;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_width_fixed: assert property (area2_width_o == 2'h1)
        else $error("area2 width is not 16 bits");
    chk_read_value: assert property ($past(rd_i) && $past(addr_i) == 4'h0 |-> rdata_o == sh_r)
        else $error("control read value wrong");
    chk_burst_follow: assert property ($stable(sh_r) |-> page_burst_o == sh_r[6])
        else $error("burst output does not follow control");
    chk_rcd_decode: assert property ($stable(sh_r) |-> ras_cas_cycles_o == {2'h0, sh_r[13:12]} + 4'h1)
        else $error("ras to cas count wrong");
    chk_col_decode: assert property ($stable(sh_r) |-> column_bits_o == {2'h0, sh_r[4:3]} + 4'h8)
        else $error("column width wrong");
    chk_ras_enabled: assert property ($rose(ras_refresh_o) |-> sh_r[2] && !sh_r[1])
        else $error("cbr refresh without cbr mode enabled");
    chk_ras_length: assert property ($fell(ras_refresh_o) |-> cnt_r == {2'h0, sh_r[9:8]} + 4'h2)
        else $error("ras assert length wrong");
    chk_ras_after_bus: assert property ($rose(ras_refresh_o) |-> !$past(bus_busy_i) && bus_hold_o)
        else $error("refresh started during bus cycle");
    chk_tpc_decode: assert property ($stable(sh_r) && !bus_hold_o && !$past(bus_hold_o) |->
        precharge_cycles_o == {2'h0, sh_r[15:14]} + 4'h1)
        else $error("normal precharge count wrong");
    chk_self_entry: assert property ($rose(self_refresh_o) |-> !$past(bus_busy_i) && sh_r[2] && sh_r[1])
        else $error("self-refresh entered wrongly");
    chk_self_quiet: assert property (self_refresh_o |-> bus_hold_o ##1 !ras_refresh_o)
        else $error("refresh ran during self-refresh");
    cover property ($rose(ras_refresh_o));
    cover property ($rose(self_refresh_o));
    cover property (page_burst_o);
    cover property ($fell(self_refresh_o));
endmodule

// file: verif/adt_ext_bus.sv
// external bus cycle engine standing in for area-2 accesses
module adt_ext_bus (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic [3:0] len_i,
    input  wire logic       hold_i,
    output logic            busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // left_r counts down the cycles still to run; busy_o stays high for len_i cycles
    logic [3:0] left_r;
    // no new cycle while refresh owns the bus
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) left_r <= 4'h0;
        else if (start_i && !hold_i) left_r <= len_i;
        else if (left_r != 4'h0) left_r <= left_r - 4'h1;
    end
    assign busy_o = left_r != 4'h0;
endmodule

// file: verif/tb_top.sv
// self-checking bench for the area-2 dram timing block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, refresh_req_i = 0, start = 0;
    logic        bus_busy_i, bus_hold_o, ras_refresh_o, self_refresh_o, page_burst_o;
    logic [3:0]  addr_i = 0, len = 0, ras_cas_cycles_o, precharge_cycles_o, column_bits_o;
    logic [15:0] wdata_i = 0, rdata_o;
    logic [1:0]  area2_width_o;
    int          n_mismatch = 0, tests_run = 0, n;
    logic [15:0] rows [4][2] = '{'{16'h0000, 16'h0000}, '{16'h5108, 16'h5108},
                                 '{16'hAEB1, 16'hA210}, '{16'hF359, 16'hF358}};
    adt_core dut_u (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .refresh_req_i, .bus_busy_i, .rdata_o,
        .bus_hold_o, .ras_refresh_o, .self_refresh_o, .page_burst_o, .area2_width_o, .ras_cas_cycles_o,
        .precharge_cycles_o, .column_bits_o);
    adt_ext_bus bus_u (.clk_i, .rst_i, .start_i(start), .len_i(len), .hold_i(bus_hold_o), .busy_o(bus_busy_i));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic chk(input string s, input logic [15:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk("rdata", e, rdata_o);
    endtask
    // bus cycle first, request one edge later, then count ras cycles
    task automatic busy_req(input logic [3:0] l, output int c);
        @(posedge clk_i);
        start <= 1'b1;
        len   <= l;
        @(posedge clk_i);
        start         <= 1'b0;
        refresh_req_i <= 1'b1;
        @(posedge clk_i);
        refresh_req_i <= 1'b0;
        c = 0;
        repeat (60) begin
            @(posedge clk_i);
            #1 if (ras_refresh_o) c++;
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h0, 16'h0000);
        chk("decode", 16'h1811, {ras_cas_cycles_o, column_bits_o, 2'h0, area2_width_o, precharge_cycles_o});
        // no external bus cycle starts before the control word is set up
        foreach (rows[i]) begin
            wr(4'h0, rows[i][0]);
            rd(4'h0, rows[i][1]);
            chk("burst", {15'h0, rows[i][1][6]}, {15'h0, page_burst_o});
            chk("rcd", {14'h0, rows[i][1][13:12]} + 16'h1, {12'h0, ras_cas_cycles_o});
            chk("cols", {14'h0, rows[i][1][4:3]} + 16'h8, {12'h0, column_bits_o});
            chk("tpc", {14'h0, rows[i][1][15:14]} + 16'h1, {12'h0, precharge_cycles_o});
        end
        wr(4'h7, 16'hFFFF);
        rd(4'h7, 16'h0000);
        rd(4'h0, 16'hF358);
        $display("register test done");
        // cbr mode with each ras field value 0 to 3, expecting a ras assert of 2 to 5 cycles
        for (int k = 0; k < 4; k++) begin
            wr(4'h0, 16'h0004 | (16'(k) << 8));
            busy_req(4'h6, n);
            chk("ras_len", 16'(k + 2), 16'(n));
        end
        wr(4'h0, 16'h0000);
        busy_req(4'h6, n);
        chk("no_refresh", 16'h0, 16'(n));
        $display("cbr test done");
        // long bus cycle first, so self-refresh entry has to wait for its end
        @(posedge clk_i);
        start <= 1'b1;
        len   <= 4'hF;
        @(posedge clk_i);
        start <= 1'b0;
        wr(4'h0, 16'h4006);
        repeat (4) @(posedge clk_i);
        #1 chk("self_wait", 16'h0, {15'h0, self_refresh_o});
        busy_req(4'h8, n);
        chk("self_quiet", 16'h8000, {self_refresh_o, 15'(n)});
        busy_req(4'h8, n);
        chk("self_ignore", 16'h8000, {self_refresh_o, 15'(n)});
        wr(4'h0, 16'h4000);
        n = 0;
        repeat (20) begin
            @(posedge clk_i);
            #1 if (bus_hold_o) n++;
        end
        chk("self_tpc", 16'h0005, 16'(n));
        chk("self_exit", 16'h0, {14'h0, self_refresh_o, bus_hold_o});
        $display("self-refresh test done");
        wr(4'h0, 16'h5108);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h0, 16'h0000);
        chk("reset_decode", 16'h1811, {ras_cas_cycles_o, column_bits_o, 2'h0, area2_width_o, precharge_cycles_o});
        $display("reset test done");
        finish_test();
    end
endmodule
bind adt_core adt_core_properties chk_u (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .bus_busy_i, .rdata_o,
    .bus_hold_o, .ras_refresh_o, .self_refresh_o, .page_burst_o, .area2_width_o, .ras_cas_cycles_o,
    .precharge_cycles_o, .column_bits_o);
